// File: hdl/lcd_multiplex_drive_timing.sv
// lcd multiplex drive timing: clock select, frame divider, cascade sync, level selection
//
// Operation
// [RULE_01] bias and multiplex follow mode and bias last written by the mode command
// [RULE_02] static mode: one backplane, two levels, segments fully on or off
// [RULE_03] 1:2 mode: two backplanes, half bias three levels or third bias four
// [RULE_04] 1:3 mode: three backplanes, third bias by default
// [RULE_05] 1:4 mode: four backplanes, third bias by default
// [RULE_06] half bias also accepted in 1:3 and 1:4 modes
// [RULE_07] bias fraction is one over one plus a, a is 1 or 2
// [RULE_08] everything timed by one working clock, internal or external
// [RULE_09] select strap low: internal oscillator runs and clock pin drives it out
// [RULE_10] select strap high: clock pin is the external clock input
// [RULE_11] frame rate is the working clock divided by 24
// [RULE_12] cascaded devices align frames through the shared sync line
// [RULE_13] display ram copied to display register and held during drive
// [RULE_14] each of 60 segments from backplane phase and its register bit
// [RULE_15] 1:4 mode: four backplanes each carry a distinct row phase
// [RULE_16] 1:3 mode: backplane 3 duplicates backplane 1
// [RULE_17] 1:2 mode: backplane 2 copies 0, backplane 3 copies 1
// [RULE_18] static mode: all four backplanes identical
// [RULE_19] system keeps the working clock running at all times
// [RULE_20] reset default: 1:4 mode, blinking off, display disabled
// [RULE_21] ram row k is multiplexed with backplane k
// [RULE_22] sync line is active low, both input and output
// [RULE_23] polarity alternates within each frame, zero net dc per element
// [RULE_24] frame counter steps one slot per active backplane and phase
`timescale 1ns/1ps

module lcd_multiplex_drive_timing #(
    parameter int OSC_DIV = lcd_drive_pkg::OSC_DIV
) (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    // apb slave
    input  wire lcd_drive_pkg::apb_req_t   apb_req,
    output lcd_drive_pkg::apb_rsp_t        apb_rsp,
    // clock source strap and clock pin
    input  wire logic                      osc_sel,
    input  wire logic                      clk_pin_in,
    output logic                           clk_pin_out,
    output logic                           clk_pin_oe,
    // cascade sync, open drain, active low
    input  wire logic                      sync_n_in,
    output logic                           sync_n_out,
    output logic                           sync_n_oe,
    // lcd drive levels
    output lcd_drive_pkg::lvl_t [3:0]      backplane_outputs,
    output lcd_drive_pkg::lvl_t [59:0]     segment_outputs
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        lcd_drive_pkg::ctrl_t                   ctrl;
        lcd_drive_pkg::ctrl_t                   act;
        logic [3:0][lcd_drive_pkg::N_SEG-1:0]   ram;
        logic [3:0][lcd_drive_pkg::N_SEG-1:0]   disp;
        logic [2:0]                             step;
        logic [3:0]                             sub;
        logic [4:0]                             frames;
        logic [31:0]                            prdata;
        logic [lcd_drive_pkg::OSC_W-1:0]        osc_cnt;
        logic                                   wclk;
        logic                                   sync_drv;
        logic [2:0]                             clk_sy;
        logic [2:0]                             osc_sy;
        logic [2:0]                             syn_sy;
        logic                                   clk_lvl;
        logic                                   syn_lvl;
        logic [1:0]                             strap_cnt;
        logic                                   strap_done;
        logic                                   ext_sel;
        lcd_drive_pkg::lvl_t [3:0]              bp;
        lcd_drive_pkg::lvl_t [59:0]             seg;
    } st_t;

    st_t s_r;
    st_t s_nxt;

    // ****************************************
    // mode helpers
    // ****************************************
    function automatic logic [3:0] step_len(lcd_drive_pkg::mode_t m);
        case (m)
            lcd_drive_pkg::MODE_STATIC: step_len = 4'(lcd_drive_pkg::FRAME_DIV / 2);
            lcd_drive_pkg::MODE_MUX2:   step_len = 4'(lcd_drive_pkg::FRAME_DIV / 4);
            lcd_drive_pkg::MODE_MUX3:   step_len = 4'(lcd_drive_pkg::FRAME_DIV / 6);
            default:                    step_len = 4'(lcd_drive_pkg::FRAME_DIV / 8);
        endcase
    endfunction : step_len

    function automatic logic [2:0] last_step(lcd_drive_pkg::mode_t m);
        case (m)
            lcd_drive_pkg::MODE_STATIC: last_step = 3'h1;
            lcd_drive_pkg::MODE_MUX2:   last_step = 3'h3;
            lcd_drive_pkg::MODE_MUX3:   last_step = 3'h5;                 // RULE_04
            default:                    last_step = 3'h7;                 // RULE_05
        endcase
    endfunction : last_step

    // row that backplane k shows; unused backplanes mirror a live one
    function automatic logic [1:0] bp_row(lcd_drive_pkg::mode_t m, logic [1:0] k);
        case (m)
            lcd_drive_pkg::MODE_STATIC: bp_row = 2'h0;                  // RULE_18
            lcd_drive_pkg::MODE_MUX2:   bp_row = {1'b0, k[0]};          // RULE_17
            lcd_drive_pkg::MODE_MUX3:   bp_row = (k == 2'h3) ? 2'h1 : k; // RULE_16
            default:                    bp_row = k;                     // RULE_15
        endcase
    endfunction : bp_row

    // selected backplane swings full scale; others sit at the bias points
    function automatic lcd_drive_pkg::lvl_t bp_lvl(lcd_drive_pkg::ctrl_t c, logic sel,
                                                   logic ph);
        if (c.mode == lcd_drive_pkg::MODE_STATIC || sel)
            bp_lvl = ph ? lcd_drive_pkg::LVL_VSS : lcd_drive_pkg::LVL_FULL; // RULE_02
        else if (c.half_bias)
            bp_lvl = lcd_drive_pkg::LVL_HALF;                               // RULE_07
        else
            bp_lvl = ph ? lcd_drive_pkg::LVL_TWO3 : lcd_drive_pkg::LVL_THIRD;
    endfunction : bp_lvl

    function automatic lcd_drive_pkg::lvl_t seg_lvl(lcd_drive_pkg::ctrl_t c, logic on,
                                                    logic ph);
        if (on)
            seg_lvl = ph ? lcd_drive_pkg::LVL_FULL : lcd_drive_pkg::LVL_VSS;
        else if (c.mode == lcd_drive_pkg::MODE_STATIC)
            seg_lvl = ph ? lcd_drive_pkg::LVL_VSS : lcd_drive_pkg::LVL_FULL; // RULE_02
        else if (c.half_bias)
            seg_lvl = lcd_drive_pkg::LVL_HALF;                              // RULE_03 RULE_06
        else
            seg_lvl = ph ? lcd_drive_pkg::LVL_THIRD : lcd_drive_pkg::LVL_TWO3;
    endfunction : seg_lvl

    // ****************************************
    // combinational next state
    // ****************************************
    logic       tick;
    logic       frame_end;
    logic       sync_fall;
    logic       realign;
    logic       frame_start;
    logic       acc;
    logic       setup;
    logic       hit;
    logic [11:0] off;
    logic [1:0] row;
    logic       blank;

    always_comb begin
        s_nxt = s_r;
        off   = apb_req.paddr - lcd_drive_pkg::ADDR_RAM;
        row   = off[lcd_drive_pkg::RAM_ROW_LSB +: 2];

        // pin synchronisers; only stages 1 and 2 are compared
        s_nxt.clk_sy = {s_r.clk_sy[1:0], clk_pin_in};
        s_nxt.osc_sy = {s_r.osc_sy[1:0], osc_sel};
        s_nxt.syn_sy = {s_r.syn_sy[1:0], sync_n_in};
        if (s_r.clk_sy[1] == s_r.clk_sy[2])
            s_nxt.clk_lvl = s_r.clk_sy[2];
        if (s_r.syn_sy[1] == s_r.syn_sy[2])
            s_nxt.syn_lvl = s_r.syn_sy[2];
        sync_fall = (s_r.syn_sy[1] == s_r.syn_sy[2]) && !s_r.syn_sy[2] && s_r.syn_lvl;

        // strap taken once the synchroniser has filled after reset
        if (!s_r.strap_done) begin
            s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
            if (s_r.strap_cnt == 2'h3) begin
                s_nxt.strap_done = 1'b1;
                s_nxt.ext_sel    = s_r.osc_sy[2];
            end
        end

        // internal oscillator: square wave, tick on its rising half
        tick = 1'b0;
        if (s_r.strap_done && !s_r.ext_sel) begin                          // RULE_09
            s_nxt.osc_cnt = s_r.osc_cnt + 1'b1;
            if (s_r.osc_cnt == lcd_drive_pkg::OSC_W'(OSC_DIV / 2 - 1)) begin
                s_nxt.osc_cnt = '0;
                s_nxt.wclk    = !s_r.wclk;
                tick          = !s_r.wclk;
            end
        end else if (s_r.strap_done) begin                                 // RULE_10
            tick = (s_r.clk_sy[1] == s_r.clk_sy[2]) && s_r.clk_sy[2] && !s_r.clk_lvl;
        end

        // frame sequencer, 24 working clocks per frame
        frame_end = (s_r.step == last_step(s_r.act.mode))
                  && (s_r.sub == step_len(s_r.act.mode) - 4'h1);
        realign   = sync_fall && !s_r.sync_drv;                             // RULE_12
        frame_start = realign || (tick && frame_end);
        if (tick) begin                                                    // RULE_08
            s_nxt.sync_drv = 1'b0;
            s_nxt.sub      = s_r.sub + 4'h1;
            if (s_r.sub == step_len(s_r.act.mode) - 4'h1) begin            // RULE_11
                s_nxt.sub  = '0;
                s_nxt.step = s_r.step + 3'h1;                              // RULE_24
            end
        end
        if (frame_start) begin
            s_nxt.step     = '0;
            s_nxt.sub      = '0;
            s_nxt.sync_drv = !realign;                                     // RULE_22
            s_nxt.act      = s_r.ctrl;                                     // RULE_01
            s_nxt.disp     = s_r.ram;                                      // RULE_13
            s_nxt.frames   = s_r.frames + 5'h1;
        end

        // drive levels, disabled display parks everything at the supply
        blank = s_r.act.blink && s_r.frames[lcd_drive_pkg::BLINK_BIT];
        for (int k = 0; k < lcd_drive_pkg::N_BP; k++) begin
            s_nxt.bp[k] = bp_lvl(s_r.act, bp_row(s_r.act.mode, 2'(k)) == s_r.step[2:1],
                                 s_r.step[0]);                             // RULE_21 RULE_23
            if (!s_r.act.enable)
                s_nxt.bp[k] = lcd_drive_pkg::LVL_FULL;
        end
        for (int j = 0; j < lcd_drive_pkg::N_SEG; j++) begin
            s_nxt.seg[j] = seg_lvl(s_r.act, s_r.disp[s_r.step[2:1]][j] && !blank,
                                   s_r.step[0]);                           // RULE_14
            if (!s_r.act.enable)
                s_nxt.seg[j] = lcd_drive_pkg::LVL_FULL;
        end

        // apb: read data captured in setup, write taken in the access cycle
        setup = apb_req.psel && !apb_req.penable;
        acc   = apb_req.psel && apb_req.penable;
        hit   = (apb_req.paddr == lcd_drive_pkg::ADDR_CTRL)
             || (apb_req.paddr == lcd_drive_pkg::ADDR_STAT)
             || (apb_req.paddr >= lcd_drive_pkg::ADDR_RAM
                 && apb_req.paddr <= lcd_drive_pkg::ADDR_RAM_HI
                 && apb_req.paddr[1:0] == 2'h0);
        if (setup) begin
            s_nxt.prdata = '0;
            if (apb_req.paddr == lcd_drive_pkg::ADDR_CTRL)
                s_nxt.prdata = 32'(s_r.ctrl);
            else if (apb_req.paddr == lcd_drive_pkg::ADDR_STAT)
                s_nxt.prdata = 32'(lcd_drive_pkg::stat_t'({s_r.frames, s_r.ext_sel,
                                                           s_r.step, s_r.act}));
            else if (hit && off[lcd_drive_pkg::RAM_HALF])
                s_nxt.prdata = 32'(s_r.ram[row][lcd_drive_pkg::N_SEG-1:lcd_drive_pkg::RAM_LO_W]);
            else if (hit)
                s_nxt.prdata = s_r.ram[row][lcd_drive_pkg::RAM_LO_W-1:0];
        end
        if (acc && apb_req.pwrite && hit) begin
            if (apb_req.paddr == lcd_drive_pkg::ADDR_CTRL)
                s_nxt.ctrl = apb_req.pwdata[$bits(lcd_drive_pkg::ctrl_t)-1:0];
            else if (apb_req.paddr == lcd_drive_pkg::ADDR_STAT)
                s_nxt.ctrl = s_r.ctrl;
            else if (off[lcd_drive_pkg::RAM_HALF])
                s_nxt.ram[row][lcd_drive_pkg::N_SEG-1:lcd_drive_pkg::RAM_LO_W] =
                    apb_req.pwdata[lcd_drive_pkg::N_SEG-lcd_drive_pkg::RAM_LO_W-1:0];
            else
                s_nxt.ram[row][lcd_drive_pkg::RAM_LO_W-1:0] = apb_req.pwdata;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r          <= '0;
            s_r.ctrl     <= lcd_drive_pkg::CTRL_RST;                       // RULE_20
            s_r.act      <= lcd_drive_pkg::CTRL_RST;
            s_r.clk_sy   <= 3'h7;
            s_r.osc_sy   <= 3'h7;
            s_r.syn_sy   <= 3'h7;
            s_r.clk_lvl  <= 1'b1;
            s_r.syn_lvl  <= 1'b1;
            s_r.bp       <= {lcd_drive_pkg::N_BP{lcd_drive_pkg::LVL_FULL}};
            s_r.seg      <= {lcd_drive_pkg::N_SEG{lcd_drive_pkg::LVL_FULL}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign apb_rsp.pready    = acc;
    assign apb_rsp.pslverr   = acc && !hit;
    assign apb_rsp.prdata    = s_r.prdata;
    assign clk_pin_out       = s_r.wclk;
    assign clk_pin_oe        = s_r.strap_done && !s_r.ext_sel;            // RULE_09 RULE_10
    assign sync_n_out        = 1'b0;
    assign sync_n_oe         = s_r.sync_drv;                               // RULE_22
    assign backplane_outputs = s_r.bp;
    assign segment_outputs   = s_r.seg;

    // ****************************************
    // assertions
    // ****************************************
    localparam int FRAME_LAST = lcd_drive_pkg::FRAME_DIV - 1;
    logic [4:0] ticks_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            ticks_r <= '0;
        else if (frame_start)
            ticks_r <= '0;
        else if (tick)
            ticks_r <= ticks_r + 5'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_frame_len;
        tick && frame_end && !realign |-> ticks_r == 5'(FRAME_LAST);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not 24 clocks"); // RULE_11

    property p_static_bp;
        $past(s_r.act.mode) == lcd_drive_pkg::MODE_STATIC |->
            backplane_outputs[0] == backplane_outputs[1]
            && backplane_outputs[0] == backplane_outputs[2]
            && backplane_outputs[0] == backplane_outputs[3];
    endproperty
    a_static_bp: assert property (p_static_bp) else $error("static backplanes differ"); // RULE_18

    property p_mux3_bp;
        $past(s_r.act.mode) == lcd_drive_pkg::MODE_MUX3 |->
            backplane_outputs[3] == backplane_outputs[1];
    endproperty
    a_mux3_bp: assert property (p_mux3_bp) else $error("bp3 not bp1 in 1:3"); // RULE_16

    property p_mux2_bp;
        $past(s_r.act.mode) == lcd_drive_pkg::MODE_MUX2 |->
            backplane_outputs[2] == backplane_outputs[0]
            && backplane_outputs[3] == backplane_outputs[1];
    endproperty
    a_mux2_bp: assert property (p_mux2_bp) else $error("1:2 backplane pairs differ"); // RULE_17

    logic [3:0] full_bp;
    for (genvar g = 0; g < lcd_drive_pkg::N_BP; g++) begin : g_full_bp
        assign full_bp[g] = backplane_outputs[g] inside {lcd_drive_pkg::LVL_VSS,
                                                          lcd_drive_pkg::LVL_FULL};
    end
    property p_mux4_one_sel;
        $past(s_r.act) == lcd_drive_pkg::ctrl_t'{blink: 1'b0, enable: 1'b1, half_bias: 1'b0,
                                                 mode: lcd_drive_pkg::MODE_MUX4} |->
            $onehot(full_bp);
    endproperty
    a_mux4_one_sel: assert property (p_mux4_one_sel) else $error("1:4 not one row"); // RULE_15

    property p_disabled_park;
        !$past(s_r.act.enable) |->
            segment_outputs == {lcd_drive_pkg::N_SEG{lcd_drive_pkg::LVL_FULL}};
    endproperty
    a_disabled_park: assert property (p_disabled_park) else $error("disabled not parked"); // RULE_20

    property p_phase_alt;
        tick && !frame_end && !realign && s_r.sub == step_len(s_r.act.mode) - 4'h1
            |=> s_r.step[0] != $past(s_r.step[0]);
    endproperty
    a_phase_alt: assert property (p_phase_alt) else $error("phase did not alternate"); // RULE_23

    property p_disp_hold;
        $changed(s_r.disp) |-> $past(frame_start);
    endproperty
    a_disp_hold: assert property (p_disp_hold) else $error("display reg changed mid frame"); // RULE_13

    property p_sync_drive;
        tick && frame_end && !realign |=> sync_n_oe ##1 (sync_n_oe throughout !tick[*2]);
    endproperty
    a_sync_drive: assert property (p_sync_drive) else $error("sync not driven at frame"); // RULE_12

endmodule : lcd_multiplex_drive_timing

// File: hdl/lcd_drive_pkg.sv
// constants, field layouts and carrier types for the lcd multiplex drive timing block
package lcd_drive_pkg;

    // ****************************************
    // geometry and timing
    // ****************************************
    localparam int N_SEG       = 60;
    localparam int N_BP        = 4;
    localparam int FRAME_DIV   = 24;
    localparam int CORE_HZ     = 200_000_000;
    localparam int OSC_HZ      = 1536;
    localparam int OSC_DIV     = CORE_HZ / OSC_HZ;
    localparam int OSC_W       = 17;
    localparam int BLINK_BIT   = 4;

    // ****************************************
    // drive levels in sixths of the lcd supply
    // ****************************************
    typedef logic [2:0] lvl_t;
    localparam lvl_t LVL_VSS   = 3'h0;
    localparam lvl_t LVL_THIRD = 3'h2;
    localparam lvl_t LVL_HALF  = 3'h3;
    localparam lvl_t LVL_TWO3  = 3'h4;
    localparam lvl_t LVL_FULL  = 3'h6;

    typedef enum logic [1:0] {
        MODE_MUX4   = 2'b00,
        MODE_STATIC = 2'b01,
        MODE_MUX2   = 2'b10,
        MODE_MUX3   = 2'b11
    } mode_t;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STAT   = 12'h004;
    localparam logic [11:0] ADDR_RAM    = 12'h010;
    localparam logic [11:0] ADDR_RAM_HI = 12'h02c;
    localparam int          RAM_ROW_LSB = 3;
    localparam int          RAM_HALF    = 2;
    localparam int          RAM_LO_W    = 32;

    typedef struct packed {
        logic  blink;
        logic  enable;
        logic  half_bias;
        mode_t mode;
    } ctrl_t;
    localparam ctrl_t CTRL_RST = '{blink: 1'b0, enable: 1'b0, half_bias: 1'b0, mode: MODE_MUX4};

    typedef struct packed {
        logic [4:0] frames;
        logic       ext_clk;
        logic [2:0] step;
        ctrl_t      act;
    } stat_t;

    // ****************************************
    // apb carrier
    // ****************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage : lcd_drive_pkg

// File: sim/lcd_far_side.sv
// far side model: cascaded partner sharing the clock pin and sync line
`timescale 1ns/1ps

module lcd_far_side (
    // clock
    input  wire logic core_clk,
    // device pins
    input  wire logic dev_clk_out,
    input  wire logic dev_clk_oe,
    input  wire logic dev_sync_oe,
    // bench control
    input  wire logic pull_sync,
    // resolved wires
    output logic      clk_wire,
    output logic      sync_wire_n,
    output logic      ext_clk
);
    // ****************************************
    // external clock, 16 core cycles a period
    // ****************************************
    logic [2:0] div_r = 3'h0;
    initial ext_clk = 1'b0;
    // free running: a halted clock would leave the glass at dc
    always @(posedge core_clk) begin
        div_r <= div_r + 3'h1;
        if (div_r == 3'h7) ext_clk <= ~ext_clk;
    end
    // ****************************************
    // pin resolution
    // ****************************************
    assign clk_wire    = dev_clk_oe ? dev_clk_out : ext_clk;
    // open drain with pull-up, low wins
    assign sync_wire_n = ~(dev_sync_oe | pull_sync);
endmodule : lcd_far_side

// File: sim/lcd_multiplex_drive_timing_tb.sv
// self-checking bench for the lcd multiplex drive timing block
`timescale 1ns/1ps

module lcd_multiplex_drive_timing_tb;
    // ****************************************
    // signals
    // ****************************************
    logic                       core_clk = 1'b0;
    logic                       rst_n;
    lcd_drive_pkg::apb_req_t    req;
    lcd_drive_pkg::apb_rsp_t    rsp;
    logic                       osc_sel, pull_sync, clk_wire, sync_wire_n, ext_clk;
    logic                       clk_pin_out, clk_pin_oe, sync_n_oe, sync_n_out;
    lcd_drive_pkg::lvl_t [3:0]  bp;
    lcd_drive_pkg::lvl_t [59:0] seg;
    logic [59:0]                ram [4];
    logic [31:0]                rd;
    logic                       er;
    int                         errors = 0;
    int                         compares = 0;

    always #2.5 core_clk = ~core_clk;

    lcd_multiplex_drive_timing #(.OSC_DIV(16)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .osc_sel(osc_sel), .clk_pin_in(clk_wire), .clk_pin_out(clk_pin_out),
        .clk_pin_oe(clk_pin_oe), .sync_n_in(sync_wire_n), .sync_n_out(sync_n_out),
        .sync_n_oe(sync_n_oe), .backplane_outputs(bp), .segment_outputs(seg));

    lcd_far_side far (.core_clk(core_clk), .dev_clk_out(clk_pin_out),
        .dev_clk_oe(clk_pin_oe), .dev_sync_oe(sync_n_oe), .pull_sync(pull_sync),
        .clk_wire(clk_wire), .sync_wire_n(sync_wire_n), .ext_clk(ext_clk));

    // ****************************************
    // compare, bus and closing tasks
    // ****************************************
    task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t bus got %h exp %h", $time, g, e);
        end
    endtask : chk_bus

    task automatic chk_drv(input logic [239:0] g, input logic [239:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t drive got %h exp %h", $time, g, e);
        end
    endtask : chk_drv

    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // one cycle gap first, so psel is never assigned twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do @(posedge core_clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic fill();
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 12'(16 + 8 * k), ram[k][31:0]);
            apb(1'b1, 12'(20 + 8 * k), {4'h0, ram[k][59:32]});
        end
    endtask : fill

    // ****************************************
    // reference model: checked mid-tick each tick
    // ****************************************
    task automatic run(input int m, input logic h, input int nfr);
        int                         n, t, s, r;
        lcd_drive_pkg::lvl_t [3:0]  eb;
        lcd_drive_pkg::lvl_t [59:0] es;
        n = (m == 0) ? 4 : (m == 1) ? 1 : (m == 2) ? 2 : 3;
        t = 0;
        // skip the write edge: a frame starting there still latches the old mode
        @(posedge core_clk);
        @(posedge sync_n_oe);
        repeat (nfr * 24) begin
            if (osc_sel) @(negedge ext_clk);
            else @(negedge clk_pin_out);
            t = sync_n_oe ? 0 : t + 1;
            s = t / (12 / n);
            for (int k = 0; k < 4; k++) begin
                r = (n == 4) ? k : (n == 3) ? ((k == 3) ? 1 : k) : (n == 2) ? k % 2 : 0;
                eb[k] = (r == s / 2) ? ((s % 2) ? 3'h0 : 3'h6) :
                        h ? 3'h3 : ((s % 2) ? 3'h4 : 3'h2);
            end
            for (int j = 0; j < 60; j++)
                es[j] = ram[s / 2][j] ? ((s % 2) ? 3'h6 : 3'h0) : (n == 1) ? eb[0] :
                        h ? 3'h3 : ((s % 2) ? 3'h2 : 3'h4);
            chk_drv(240'(bp), 240'(eb));
            chk_drv(240'(seg), 240'(es));
        end
    endtask : run

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h1825_6a97));
        rst_n = 1'b0;
        req = '0;
        osc_sel = 1'b0;
        pull_sync = 1'b0;
        repeat (3) @(posedge core_clk);
        chk_drv(240'(bp), 240'({4{3'h6}}));
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk_bus(rd, 32'h0000_0000);
        apb(1'b1, 12'h040, 32'hffff_ffff);
        chk_bus({31'h0, er}, 32'h0000_0001);
        $display("reset and bus test done");
        for (int k = 0; k < 4; k++) ram[k] = 60'({$urandom(), $urandom()});
        fill();
        chk_bus({31'h0, clk_pin_oe}, 32'h0000_0001);
        for (int m = 0; m < 4; m++)
            for (int h = 0; h < 2; h++) begin
                apb(1'b1, 12'h000, 32'(8 + 4 * h + m));
                run(m, h[0], 1);
                $display("mode %0d half %0d test done", m, h);
            end
        @(posedge sync_n_oe);
        repeat (10) @(posedge clk_pin_out);
        pull_sync <= 1'b1;
        repeat (16) @(posedge core_clk);
        pull_sync <= 1'b0;
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk_bus({29'h0, rd[7:5]}, 32'h0000_0000);
        chk_bus({31'h0, sync_n_out}, 32'h0000_0000);
        $display("sync test done");
        rst_n <= 1'b0;
        osc_sel <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk_bus({30'h0, rd[8], clk_pin_oe}, 32'h0000_0002);
        fill();
        apb(1'b1, 12'h000, 32'h0000_0008);
        run(0, 1'b0, 2);
        $display("external clock test done");
        apb(1'b1, 12'h000, 32'h0000_0018);
        do apb(1'b0, 12'h004, 32'h0000_0000); while (rd[13:9] != 5'h10);
        for (int k = 0; k < 4; k++) ram[k] = '0;
        run(0, 1'b0, 1);
        $display("blink test done");
        conclude();
    end

    initial begin
        #200_000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
endmodule : lcd_multiplex_drive_timing_tb
